// ### common/sfr_pkg.sv
package sfr_pkg;
  localparam logic [7:0] OFS_PORT_ZERO_LATCH = 8'h80;
  localparam logic [7:0] OFS_STACK_POINTER = 8'h81;
  localparam logic [7:0] OFS_DATA_PTR_LOW = 8'h82;
  localparam logic [7:0] OFS_DATA_PTR_HIGH = 8'h83;
  localparam logic [7:0] OFS_DATA_POINTER_SELECT = 8'h86;
  localparam logic [7:0] OFS_POWER_CONTROL = 8'h87;
  localparam logic [7:0] OFS_TIMER_CONTROL = 8'h88;
  localparam logic [7:0] OFS_TIMER_MODE_SELECT = 8'h89;
  localparam logic [7:0] OFS_TIMER0_COUNT_LOW = 8'h8a;
  localparam logic [7:0] OFS_TIMER1_COUNT_LOW = 8'h8b;
  localparam logic [7:0] OFS_TIMER0_COUNT_HIGH = 8'h8c;
  localparam logic [7:0] OFS_TIMER1_COUNT_HIGH = 8'h8d;
  localparam logic [7:0] OFS_CLOCK_DIVIDER_CONTROL = 8'h8e;
  localparam logic [7:0] OFS_PORT_ONE_LATCH = 8'h90;
  localparam logic [7:0] OFS_EXT_INT_FLAGS = 8'h91;
  localparam logic [7:0] OFS_MEMORY_PAGE = 8'h92;
  localparam logic [7:0] OFS_PORT_ZERO_DIRECTION = 8'h94;
  localparam logic [7:0] OFS_PORT_ZERO_ALTFUNC = 8'h95;
  localparam logic [7:0] OFS_PORT_ONE_DIRECTION = 8'h96;
  localparam logic [7:0] OFS_PORT_ONE_ALTFUNC = 8'h97;
  localparam logic [7:0] OFS_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] OFS_SERIAL_BUFFER = 8'h99;
  localparam logic [7:0] OFS_RADIO_PORT = 8'ha0;
  localparam logic [7:0] OFS_CONVERTER_CONTROL = 8'ha1;
  localparam logic [7:0] OFS_CONVERTER_RESULT_HIGH = 8'ha2;
  localparam logic [7:0] OFS_CONVERTER_RESULT_LOW = 8'ha3;
  localparam logic [7:0] OFS_CONVERTER_STATIC_CONFIG = 8'ha4;
  localparam logic [7:0] OFS_INTERRUPT_ENABLE = 8'ha8;
  localparam logic [7:0] OFS_PULSE_WIDTH_CONTROL = 8'ha9;
  localparam logic [7:0] OFS_PULSE_WIDTH_DUTY = 8'haa;
  localparam logic [7:0] OFS_WDT_RTC_VALUE_HIGH = 8'hab;
  localparam logic [7:0] OFS_WDT_RTC_VALUE_LOW = 8'hac;
  localparam logic [7:0] OFS_WDT_RTC_COMMAND = 8'had;
  localparam logic [7:0] OFS_RESET_CAUSE = 8'hb1;
  localparam logic [7:0] OFS_SERIAL_PERIPH_DATA = 8'hb2;
  localparam logic [7:0] OFS_SERIAL_PERIPH_ROUTING = 8'hb3;
  localparam logic [7:0] OFS_SERIAL_PERIPH_CLOCK_DIV = 8'hb4;
  localparam logic [7:0] OFS_TICK_DIVIDER = 8'hb5;
  localparam logic [7:0] OFS_CLOCK_STOP_CONTROL = 8'hb6;
  localparam logic [7:0] OFS_INTERRUPT_PRIORITY = 8'hb8;
  localparam logic [7:0] OFS_TIMER2_CONTROL = 8'hc8;
  localparam logic [7:0] OFS_PROGRAM_STATUS_WORD = 8'hd0;
  localparam logic [7:0] OFS_EXT_INT_WDT_CONTROL = 8'hd8;
  localparam logic [7:0] OFS_ARITH_RESULT_REG = 8'he0;
  localparam logic [7:0] OFS_EXT_INT_ENABLE = 8'he8;
  localparam logic [7:0] OFS_MULTIPLY_OPERAND_REG = 8'hf0;
  localparam logic [7:0] OFS_EXT_INT_PRIORITY = 8'hf8;
  localparam logic [7:0] OFS_SILICON_REVISION = 8'hfe;
  localparam logic [7:0] OFS_RESERVED_TOP = 8'hff;

  // writable plain registers, one table entry each
  localparam int NUM_PLAIN = 45;
  localparam logic [7:0] PLAIN_OFS [NUM_PLAIN] = '{
    8'h80, 8'h81, 8'h82, 8'h83, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b,
    8'h8c, 8'h8d, 8'h8e, 8'h90, 8'h91, 8'h92, 8'h94, 8'h95, 8'h96, 8'h97,
    8'h98, 8'h99, 8'ha0, 8'ha1, 8'ha4, 8'ha8, 8'ha9, 8'haa, 8'hab, 8'hac,
    8'had, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'hb6, 8'hb8, 8'hc8, 8'hd8,
    8'he0, 8'he8, 8'hf0, 8'hf8, 8'h00
  };
  localparam logic [7:0] PLAIN_RST [NUM_PLAIN] = '{
    8'hff, 8'h07, 8'h00, 8'h00, 8'h00, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h01, 8'hff, 8'h08, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00,
    8'h00, 8'h00, 8'h80, 8'h80, 8'h0a, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h1d, 8'h00, 8'h80, 8'h00, 8'h40,
    8'h00, 8'he0, 8'h00, 8'he0, 8'h00
  };
  // last entry is an unused slot at offset 0, never decoded
  localparam int PLAIN_USED = 44;
  localparam int IDX_PORT_ZERO = 0;
  localparam int IDX_ARITH = 40;
  localparam int IDX_MULT = 42;

  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam int PSW_CARRY_BIT = 7;
  localparam int PSW_HALF_BIT = 6;
  localparam int PSW_USER_A_BIT = 5;
  localparam int PSW_BANK_HI_BIT = 4;
  localparam int PSW_BANK_LO_BIT = 3;
  localparam int PSW_OVER_BIT = 2;
  localparam int PSW_USER_B_BIT = 1;
  localparam int PSW_PARITY_BIT = 0;
  localparam logic [7:0] BANK_BASE_STEP = 8'h08;
endpackage

// ### design/sfr_map_and_status_word.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
// How it works
// (R1) carry flag follows arithmetic carry or borrow
// (R2) half carry flag follows nibble carry or borrow
// (R3) overflow flag set on carry, borrow, mul/div overflow
// (R4) parity bit is xor of accumulator bits
// (R5) bank bits pick working register base 0..0x18
// (R6) user flags only written by software
// (R7) status word at 0xd0, resets to zero
// (R8) ports and radio sit at standard port addresses
// (R9) revision at 0xfe, read only
// (R10) software never touches reserved 0xff
// (R11) every register loads its reset value
// (R12) port zero bit-addressable, drives pins nine..two, resets ones
// (R13) unmapped reads give zero, writes ignored
module sfr_map_and_status_word #(
  parameter logic [7:0] SILICON_REV = 8'h5a  // value arbitrary
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic arith_upd,
  input wire logic arith_carry,
  input wire logic arith_half,
  input wire logic arith_over,
  input wire logic acc_load,
  input wire logic [7:0] acc_value,
  input wire logic [7:0] conv_high,
  input wire logic [7:0] conv_low,
  output logic [1:0] bank_sel,
  output logic [7:0] bank_base,
  output logic [7:0] gpio_pins_out,
  output logic [7:0] accumulator
);
  import sfr_pkg::*;

  logic [7:0] regs_r [NUM_PLAIN];
  logic [7:0] psw_r;
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic parity;
  logic addr_known;

  // core accumulator loads win over a same-cycle software write
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PLAIN; gi++) begin : g_plain
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          regs_r[gi] <= PLAIN_RST[gi]; // see (R11) see (R12)
        end else if (gi == IDX_ARITH && acc_load) begin
          regs_r[gi] <= acc_value;
        end else if (gi < PLAIN_USED && sfr_wr && sfr_addr == PLAIN_OFS[gi]) begin
          regs_r[gi] <= sfr_wdata; // see (R8)
        end
      end
    end
  endgenerate

  // arithmetic beats software on the three flags it owns
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      psw_r <= PSW_RESET; // see (R7)
    end else begin
      if (sfr_wr && sfr_addr == OFS_PROGRAM_STATUS_WORD) begin
        psw_r <= sfr_wdata; // see (R6)
      end
      if (arith_upd) begin
        psw_r[PSW_CARRY_BIT] <= arith_carry; // see (R1)
        psw_r[PSW_HALF_BIT] <= arith_half; // see (R2)
        psw_r[PSW_OVER_BIT] <= arith_over; // see (R3)
      end
    end
  end

  assign parity = ^regs_r[IDX_ARITH]; // see (R4)
  assign bank_sel = {psw_r[PSW_BANK_HI_BIT], psw_r[PSW_BANK_LO_BIT]};
  assign bank_base = 8'({6'h00, bank_sel} * BANK_BASE_STEP); // see (R5)
  assign gpio_pins_out = regs_r[IDX_PORT_ZERO]; // see (R12)
  assign accumulator = regs_r[IDX_ARITH];

  always_comb begin
    rdata_nxt = 8'h00; // see (R13)
    addr_known = 1'b0;
    for (int i = 0; i < PLAIN_USED; i++) begin
      if (sfr_addr == PLAIN_OFS[i]) begin
        rdata_nxt = regs_r[i];
        addr_known = 1'b1;
      end
    end
    // decoded specials that sit outside the plain table
    if (sfr_addr == OFS_PROGRAM_STATUS_WORD || sfr_addr == OFS_CONVERTER_RESULT_HIGH ||
        sfr_addr == OFS_CONVERTER_RESULT_LOW || sfr_addr == OFS_SILICON_REVISION) begin
      addr_known = 1'b1;
    end
    case (sfr_addr)
      OFS_PROGRAM_STATUS_WORD: rdata_nxt = {psw_r[7:1], parity};
      OFS_CONVERTER_RESULT_HIGH: rdata_nxt = conv_high;
      OFS_CONVERTER_RESULT_LOW: rdata_nxt = conv_low;
      OFS_SILICON_REVISION: rdata_nxt = SILICON_REV; // see (R9)
      default: ;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= sfr_rd ? rdata_nxt : 8'h00;
    end
  end
  assign sfr_rdata = rdata_r;

  property p_psw_reset;
    @(posedge core_clk) $rose(nrst) |-> psw_r == PSW_RESET;
  endproperty
  a_psw_reset: assert property (p_psw_reset) else $error("psw not zero after reset"); // see (R7)

  property p_carry;
    @(posedge core_clk) disable iff (!nrst)
      arith_upd |=> psw_r[PSW_CARRY_BIT] == $past(arith_carry);
  endproperty
  a_carry: assert property (p_carry) else $error("carry flag wrong"); // see (R1)

  property p_half;
    @(posedge core_clk) disable iff (!nrst)
      arith_upd |=> psw_r[PSW_HALF_BIT] == $past(arith_half);
  endproperty
  a_half: assert property (p_half) else $error("half carry wrong"); // see (R2)

  property p_over;
    @(posedge core_clk) disable iff (!nrst)
      arith_upd |=> psw_r[PSW_OVER_BIT] == $past(arith_over);
  endproperty
  a_over: assert property (p_over) else $error("overflow wrong"); // see (R3)

  property p_parity;
    @(posedge core_clk) disable iff (!nrst)
      sfr_rd && sfr_addr == OFS_PROGRAM_STATUS_WORD |=> sfr_rdata[0] == ^$past(accumulator);
  endproperty
  a_parity: assert property (p_parity) else $error("parity wrong"); // see (R4)

  property p_bank;
    @(posedge core_clk) disable iff (!nrst)
      bank_base == {3'b000, bank_sel, 3'b000};
  endproperty
  a_bank: assert property (p_bank) else $error("bank base wrong"); // see (R5)

  property p_user_hold;
    @(posedge core_clk) disable iff (!nrst)
      !(sfr_wr && sfr_addr == OFS_PROGRAM_STATUS_WORD) |=>
        $stable({psw_r[PSW_USER_A_BIT], psw_r[PSW_USER_B_BIT]});
  endproperty
  a_user_hold: assert property (p_user_hold) else $error("user flag moved"); // see (R6)

  property p_rev;
    @(posedge core_clk) disable iff (!nrst)
      sfr_rd && sfr_addr == OFS_SILICON_REVISION |=> sfr_rdata == SILICON_REV;
  endproperty
  a_rev: assert property (p_rev) else $error("revision wrong"); // see (R9)

  property p_unmapped;
    @(posedge core_clk) disable iff (!nrst)
      sfr_rd && !addr_known |=> sfr_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // see (R13)

  // idle bus must not leak stale read data
  property p_rd_idle;
    @(posedge core_clk) disable iff (!nrst)
      !sfr_rd |=> sfr_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared"); // see (R13)

  property p_psw_write;
    @(posedge core_clk) disable iff (!nrst)
      sfr_wr && sfr_addr == OFS_PROGRAM_STATUS_WORD && !arith_upd |=>
        psw_r == $past(sfr_wdata);
  endproperty
  a_psw_write: assert property (p_psw_write) else $error("status word write lost"); // see (R7)

  property p_bank_write;
    @(posedge core_clk) disable iff (!nrst)
      sfr_wr && sfr_addr == OFS_PROGRAM_STATUS_WORD |=>
        bank_sel == $past(sfr_wdata[PSW_BANK_HI_BIT:PSW_BANK_LO_BIT]);
  endproperty
  a_bank_write: assert property (p_bank_write) else $error("bank select write lost"); // see (R5)

  // flags only move on arithmetic or a software write
  property p_carry_hold;
    @(posedge core_clk) disable iff (!nrst)
      !arith_upd && !(sfr_wr && sfr_addr == OFS_PROGRAM_STATUS_WORD) |=>
        $stable(psw_r[PSW_CARRY_BIT]);
  endproperty
  a_carry_hold: assert property (p_carry_hold) else $error("carry moved"); // see (R1)

  property p_half_hold;
    @(posedge core_clk) disable iff (!nrst)
      !arith_upd && !(sfr_wr && sfr_addr == OFS_PROGRAM_STATUS_WORD) |=>
        $stable(psw_r[PSW_HALF_BIT]);
  endproperty
  a_half_hold: assert property (p_half_hold) else $error("half carry moved"); // see (R2)

  property p_over_hold;
    @(posedge core_clk) disable iff (!nrst)
      !arith_upd && !(sfr_wr && sfr_addr == OFS_PROGRAM_STATUS_WORD) |=>
        $stable(psw_r[PSW_OVER_BIT]);
  endproperty
  a_over_hold: assert property (p_over_hold) else $error("overflow moved"); // see (R3)

  property p_acc_load;
    @(posedge core_clk) disable iff (!nrst)
      acc_load |=> accumulator == $past(acc_value);
  endproperty
  a_acc_load: assert property (p_acc_load) else $error("accumulator load lost"); // see (R4)

  property p_tick_reset;
    @(posedge core_clk) $rose(nrst) |-> regs_r[35] == 8'h1d && regs_r[5] == 8'h30;
  endproperty
  a_tick_reset: assert property (p_tick_reset) else $error("divider reset wrong"); // see (R11)

  property p_port_one;
    @(posedge core_clk) disable iff (!nrst)
      sfr_wr && sfr_addr == OFS_PORT_ONE_LATCH |=> regs_r[13] == $past(sfr_wdata);
  endproperty
  a_port_one: assert property (p_port_one) else $error("port one write lost"); // see (R8)

  property p_radio;
    @(posedge core_clk) disable iff (!nrst)
      sfr_wr && sfr_addr == OFS_RADIO_PORT |=> regs_r[22] == $past(sfr_wdata);
  endproperty
  a_radio: assert property (p_radio) else $error("radio write lost"); // see (R8)

  // converter result is read live, not latched
  property p_conv_high;
    @(posedge core_clk) disable iff (!nrst)
      sfr_rd && sfr_addr == OFS_CONVERTER_RESULT_HIGH |=> sfr_rdata == $past(conv_high);
  endproperty
  a_conv_high: assert property (p_conv_high) else $error("converter high wrong"); // see (R13)

  property p_rev_write;
    @(posedge core_clk) disable iff (!nrst)
      sfr_wr && sfr_addr == OFS_SILICON_REVISION |=> $stable(gpio_pins_out);
  endproperty
  a_rev_write: assert property (p_rev_write) else $error("revision write leaked"); // see (R9)

  property p_sp_reset;
    @(posedge core_clk) $rose(nrst) |-> regs_r[1] == 8'h07 && regs_r[IDX_PORT_ZERO] == 8'hff;
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("reset value wrong"); // see (R11)

  property p_p0_write;
    @(posedge core_clk) disable iff (!nrst)
      sfr_wr && sfr_addr == OFS_PORT_ZERO_LATCH |=> gpio_pins_out == $past(sfr_wdata);
  endproperty
  a_p0_write: assert property (p_p0_write) else $error("port zero write lost"); // see (R12)

  c_arith: cover property (@(posedge core_clk) disable iff (!nrst) arith_upd && arith_carry);
  c_bank3: cover property (@(posedge core_clk) disable iff (!nrst) bank_sel == 2'b11);
  c_acc: cover property (@(posedge core_clk) disable iff (!nrst) acc_load);
  c_unmapped: cover property (@(posedge core_clk) disable iff (!nrst) sfr_rd && !addr_known);
  c_rd_psw: cover property (@(posedge core_clk) disable iff (!nrst)
    sfr_rd && sfr_addr == OFS_PROGRAM_STATUS_WORD);
endmodule

// ### bench/sfr_map_and_status_word_tb.sv
`timescale 1ns/10ps
module sfr_map_and_status_word_tb;
  import sfr_pkg::*;
  localparam logic [7:0] REV = 8'h3c;  // value arbitrary
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic arith_upd = 1'b0;
  logic arith_carry = 1'b0;
  logic arith_half = 1'b0;
  logic arith_over = 1'b0;
  logic acc_load = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] acc_value = 8'h00;
  logic [7:0] conv_high = 8'h00;
  logic [7:0] conv_low = 8'h00;
  logic [7:0] sfr_rdata, bank_base, gpio_pins_out, accumulator, rd_v;
  logic [1:0] bank_sel;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;

  sfr_map_and_status_word #(.SILICON_REV(REV)) sfr_map_and_status_word_inst (
    .core_clk(core_clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .arith_upd(arith_upd),
    .arith_carry(arith_carry), .arith_half(arith_half), .arith_over(arith_over),
    .acc_load(acc_load), .acc_value(acc_value), .conv_high(conv_high),
    .conv_low(conv_low), .bank_sel(bank_sel), .bank_base(bank_base),
    .gpio_pins_out(gpio_pins_out), .accumulator(accumulator));

  always #2.5 core_clk = ~core_clk;

  task end_of_test;
    if (failures == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // the whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      end_of_test;
    end
  end

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
    #1;
  endtask

  // data stands only in the cycle after the strobe
  task rd(input logic [7:0] a);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    #1 rd_v = sfr_rdata;
  endtask

  task do_reset;
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
  endtask

  task t_reset;
    for (int i = 0; i < PLAIN_USED; i++) begin
      rd(PLAIN_OFS[i]);
      chk(rd_v, PLAIN_RST[i]);
    end
    rd(OFS_PROGRAM_STATUS_WORD);
    chk(rd_v, PSW_RESET);
    chk(gpio_pins_out, 8'hff);
  endtask

  task t_bank;
    for (int b = 0; b < 4; b++) begin
      wr(OFS_PROGRAM_STATUS_WORD, 8'(b * 8));
      chk({6'h00, bank_sel}, 8'(b));
      chk(bank_base, 8'(b * 8));
    end
  endtask

  task t_arith;
    wr(OFS_PROGRAM_STATUS_WORD, 8'h22);
    for (int k = 0; k < 8; k++) begin
      @(posedge core_clk);
      arith_upd <= 1'b1;
      {arith_carry, arith_half, arith_over} <= 3'(k);
      @(posedge core_clk);
      arith_upd <= 1'b0;
      rd(OFS_PROGRAM_STATUS_WORD);
      chk(rd_v, {k[2], k[1], 3'b100, k[0], 2'b10});
    end
  endtask

  task t_parity;
    logic [7:0] v;
    for (int k = 0; k < 6; k++) begin
      v = 8'h01 << k | 8'(k * 3);
      @(posedge core_clk);
      acc_load <= 1'b1;
      acc_value <= v;
      @(posedge core_clk);
      acc_load <= 1'b0;
      rd(OFS_PROGRAM_STATUS_WORD);
      chk({7'h00, rd_v[0]}, {7'h00, ^v});
      chk(accumulator, v);
    end
    wr(OFS_ARITH_RESULT_REG, 8'h07);
    rd(OFS_PROGRAM_STATUS_WORD);
    chk({7'h00, rd_v[0]}, 8'h01);
  endtask

  task t_readonly;
    @(posedge core_clk);
    conv_high <= 8'h12;
    conv_low <= 8'h34;
    wr(OFS_SILICON_REVISION, ~REV);
    rd(OFS_SILICON_REVISION);
    chk(rd_v, REV);
    wr(OFS_CONVERTER_RESULT_HIGH, 8'hee);
    rd(OFS_CONVERTER_RESULT_HIGH);
    chk(rd_v, 8'h12);
    rd(OFS_CONVERTER_RESULT_LOW);
    chk(rd_v, 8'h34);
    // probe an unmapped hole; the reserved top address is never touched
    wr(8'h8f, 8'h55);
    rd(8'h8f);
    chk(rd_v, 8'h00);
    wr(OFS_PORT_ZERO_LATCH, 8'ha5);
    rd(OFS_PORT_ZERO_LATCH);
    chk(rd_v, 8'ha5);
    // read data gone one cycle later
    @(posedge core_clk);
    #1 chk(sfr_rdata, 8'h00);
    chk(gpio_pins_out, 8'ha5);
    wr(OFS_RADIO_PORT, 8'h3c);
    wr(OFS_PORT_ONE_LATCH, 8'h5a);
    rd(OFS_RADIO_PORT);
    chk(rd_v, 8'h3c);
    rd(OFS_PORT_ONE_LATCH);
    chk(rd_v, 8'h5a);
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset;
    t_bank;
    t_arith;
    t_parity;
    t_readonly;
    // second reset in mid-run must restore every value
    do_reset;
    t_reset;
    end_of_test;
  end
endmodule
